// ===== design/mvd_pkg.sv
// Purpose: shared constants and types for the move instruction decoder
// Assumes: 14-bit program words, 7-bit file addresses, 8-bit data
// Notes: opcode patterns are given as value and mask pairs
package mvd_pkg;

    localparam int INSTR_W = 14;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    // -------------------------------------------------------------
    // opcode patterns
    // -------------------------------------------------------------
    localparam logic [13:0] MOVE_FILE_VAL = 14'h0800;
    localparam logic [13:0] MOVE_FILE_MSK = 14'h3f00;
    localparam logic [13:0] STORE_ACC_VAL = 14'h0080;
    localparam logic [13:0] STORE_ACC_MSK = 14'h3f80;
    localparam logic [13:0] OPT_LOAD_VAL = 14'h0062;
    localparam logic [13:0] OPT_LOAD_MSK = 14'h3fff;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int DEST_BIT = 7;
    localparam int ADDR_LSB = 0;

    // -------------------------------------------------------------
    // reset values and defaults
    // -------------------------------------------------------------
    localparam logic [7:0] OPT_RESET = 8'hff;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [6:0] OPT_ADDR_DEFAULT = 7'h01;
    localparam int EXEC_CYCLES = 1;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic moveFile;
        logic storeAcc;
        logic optLoad;
        logic destFile;
        logic [6:0] addr;
    } mvd_op_s;

    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } mvd_wr_s;

endpackage

// ===== design/mvd_decode.sv
// Purpose: combinational opcode decode for the three move instructions
// Assumes: word is only meaningful while the caller qualifies it
// Notes: patterns do not overlap, so no priority is needed here
`timescale 1ns/1ps
`default_nettype none

module mvd_decode
(
    // instruction in
    input wire logic [13:0] instrWord,
    input wire logic instrValid,
    // decoded operation out
    output var mvd_pkg::mvd_op_s op
);

    function automatic logic matchOp(input logic [13:0] w,
                                     input logic [13:0] val,
                                     input logic [13:0] msk);
        matchOp = ((w & msk) == val);
    endfunction

    always_comb
    begin
        op.moveFile = instrValid && matchOp(instrWord,
            mvd_pkg::MOVE_FILE_VAL, mvd_pkg::MOVE_FILE_MSK);
        op.storeAcc = instrValid && matchOp(instrWord,
            mvd_pkg::STORE_ACC_VAL, mvd_pkg::STORE_ACC_MSK);
        op.optLoad = instrValid && matchOp(instrWord,
            mvd_pkg::OPT_LOAD_VAL, mvd_pkg::OPT_LOAD_MSK);
        op.destFile = instrWord[mvd_pkg::DEST_BIT];
        op.addr = instrWord[mvd_pkg::ADDR_LSB +: 7];
    end

endmodule

`default_nettype wire

// ===== design/mvd_core.sv
// Purpose: execute stage for the file move, accumulator store and
//          legacy option load instructions
// Assumes: the core presents the addressed file value with the word
// Notes: all results register on the edge that takes the word
//
// Summary of operation
// - recognise the file move and forward the read value to its destination
// - file move with destination bit clear loads the accumulator
// - file move with destination bit set writes back, accumulator kept
// - file move sets zero flag when the moved value is zero
// - store writes the accumulator to the addressed file, flags kept
// - legacy option load copies the accumulator into the option register
// - option register also reads and writes at its file address
`timescale 1ns/1ps
`default_nettype none

module mvd_core
#(
    parameter logic [6:0] OPT_ADDR = mvd_pkg::OPT_ADDR_DEFAULT
)
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clkEn,
    // instruction stream
    input wire logic [13:0] instrWord,
    input wire logic instrValid,
    // file register read data for the addressed file
    input wire logic [7:0] fileRdData,
    // accumulator writes from other instructions
    input wire logic accWrEn,
    input wire logic [7:0] accWrData,
    // zero flag writes from other instructions
    input wire logic zeroWrEn,
    input wire logic zeroWrData,
    // file register write port
    output var mvd_pkg::mvd_wr_s fileWr,
    // architectural state
    output logic [7:0] accumulator,
    output logic zeroFlag,
    output logic [7:0] optionReg,
    // status
    output logic instrDone,
    output logic instrOther
);

    // -------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------
    logic [1:0] rstSync_r;
    logic rstSyncN;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rstSync_r <= 2'h0;
        else if (clkEn)
            rstSync_r <= {rstSync_r[0], 1'b1};
    end

    assign rstSyncN = rstSync_r[1];

    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    mvd_pkg::mvd_op_s op;

    mvd_decode u_decode
    (
        .instrWord(instrWord),
        .instrValid(instrValid),
        .op(op)
    );

    function automatic logic isOptAddr(input logic [6:0] a);
        isOptAddr = (a == OPT_ADDR);
    endfunction

    // -------------------------------------------------------------
    // operand select
    // -------------------------------------------------------------
    logic [7:0] optionReg_r;
    logic [7:0] srcData;

    always_comb
    begin
        srcData = isOptAddr(op.addr) ? optionReg_r : fileRdData;
    end

    // -------------------------------------------------------------
    // execute next state
    // -------------------------------------------------------------
    mvd_pkg::mvd_wr_s fileWr_r;
    mvd_pkg::mvd_wr_s fileWr_nxt;
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic zero_r;
    logic zero_nxt;
    logic [7:0] optionReg_nxt;
    logic done_r;
    logic done_nxt;
    logic other_r;
    logic other_nxt;
    logic intWr;
    logic [7:0] intWrData;

    always_comb
    begin
        fileWr_nxt = '0;
        acc_nxt = acc_r;
        zero_nxt = zero_r;
        optionReg_nxt = optionReg_r;
        intWr = 1'b0;
        intWrData = acc_r;
        done_nxt = op.moveFile || op.storeAcc || op.optLoad;
        other_nxt = instrValid && !done_nxt;

        // other instructions may own the accumulator and flag; the
        // decoded move wins since both should never occur together
        if (accWrEn)
            acc_nxt = accWrData;
        if (zeroWrEn)
            zero_nxt = zeroWrData;

        if (op.moveFile)
        begin
            zero_nxt = (srcData == 8'h00);
            if (op.destFile)
            begin
                intWr = 1'b1;
                intWrData = srcData;
            end
            else
            begin
                acc_nxt = srcData;
            end
        end
        else if (op.storeAcc)
        begin
            intWr = 1'b1;
            intWrData = acc_r;
        end
        else if (op.optLoad)
        begin
            optionReg_nxt = acc_r;
        end

        if (intWr)
        begin
            if (isOptAddr(op.addr))
            begin
                optionReg_nxt = intWrData;
            end
            else
            begin
                fileWr_nxt.en = 1'b1;
                fileWr_nxt.addr = op.addr;
                fileWr_nxt.data = intWrData;
            end
        end
    end

    // -------------------------------------------------------------
    // execute registers
    // -------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            fileWr_r <= '0;
            acc_r <= mvd_pkg::ACC_RESET;
            zero_r <= 1'b0;
            optionReg_r <= mvd_pkg::OPT_RESET;
            done_r <= 1'b0;
            other_r <= 1'b0;
        end
        else if (clkEn)
        begin
            fileWr_r <= fileWr_nxt;
            acc_r <= acc_nxt;
            zero_r <= zero_nxt;
            optionReg_r <= optionReg_nxt;
            done_r <= done_nxt;
            other_r <= other_nxt;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign fileWr = fileWr_r;
    assign accumulator = acc_r;
    assign zeroFlag = zero_r;
    assign optionReg = optionReg_r;
    assign instrDone = done_r;
    assign instrOther = other_r;

endmodule

`default_nettype wire

// ===== verif/mvd_core_assertions.sv
// Purpose: port checker for mvd_core
// Assumes: words are taken from the third enabled edge after reset
// Notes: bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module mvd_core_assertions
#(
    parameter logic [6:0] OPT_ADDR = 7'h01
)
(
    // clock, reset, inputs
    input wire logic mclk, rstn, clkEn, instrValid,
    input wire logic [13:0] instrWord,
    input wire logic [7:0] fileRdData, accWrData,
    input wire logic accWrEn, zeroWrEn, zeroWrData,
    // outputs
    input wire mvd_pkg::mvd_wr_s fileWr,
    input wire logic [7:0] accumulator, optionReg,
    input wire logic zeroFlag, instrDone, instrOther
);
    // mirror of the internal reset sync, ports alone cannot show it
    logic [1:0] rdy_r, rdy_nxt;
    always_comb rdy_nxt = (clkEn && rdy_r != 2'h2) ? rdy_r + 2'h1 : rdy_r;
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn) rdy_r <= 2'h0;
        else rdy_r <= rdy_nxt;
    wire tk = rdy_r == 2'h2 && clkEn && instrValid;
    wire [6:0] ad = instrWord[6:0];
    wire oa = ad == OPT_ADDR;
    wire d = instrWord[7];
    wire mv = tk && (instrWord & 14'h3f00) == mvd_pkg::MOVE_FILE_VAL;
    wire st = tk && (instrWord & 14'h3f80) == mvd_pkg::STORE_ACC_VAL;
    wire op = tk && instrWord == mvd_pkg::OPT_LOAD_VAL;
    wire kn = mv || st || op;
    wire [7:0] src = oa ? optionReg : fileRdData;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_load_acc: assert property (mv && !d |=>
        accumulator == $past(src)) else $error("move load wrong");
    a_write_back: assert property (mv && d && !oa |=>
        fileWr == {1'h1, $past(ad), $past(fileRdData)}) else $error("wb");
    a_keep_acc: assert property (mv && d && !accWrEn |=>
        $stable(accumulator)) else $error("acc changed");
    a_zero_flag: assert property (mv |=>
        zeroFlag == ($past(src) == 8'h00)) else $error("zero wrong");
    a_store_file: assert property (st && !oa |=>
        fileWr == {1'h1, $past(ad), $past(accumulator)}) else $error("st");
    a_flags_kept: assert property ((st || op) && !zeroWrEn |=>
        $stable(zeroFlag)) else $error("flag changed");
    a_option_load: assert property (op || st && oa |=>
        optionReg == $past(accumulator) && !fileWr.en) else $error("opt");
    a_one_cycle: assert property (tk |=>
        instrDone == $past(kn) && instrOther != $past(kn)) else $error("done");
    cover property (mv && !d);
    cover property (st && oa);
    cover property (op);
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: self-checking bench for mvd_core
// Assumes: clkEn held high; other writers idle while words run
// Notes: driver queues expected results, monitor pops them
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [6:0] OA = 7'h01;
    logic mclk = 1'h0, rstn = 1'h0, clkEn = 1'h1, instrValid = 1'h0;
    logic [13:0] instrWord = 14'h0;
    logic [7:0] fileRdData = 8'h0, accWrData = 8'h0;
    logic accWrEn = 1'h0, zeroWrEn = 1'h0, zeroWrData = 1'h0;
    mvd_pkg::mvd_wr_s fileWr;
    logic [7:0] accumulator, optionReg, mAcc = 8'h00, mOpt = 8'hff;
    logic zeroFlag, instrDone, instrOther, mZ = 1'h0;
    logic [33:0] q[$];
    int n_fail = 0, check_count = 0, cyc = 0;
    always #5 mclk = ~mclk;
    mvd_core #(.OPT_ADDR(OA)) u_dut (.mclk, .rstn, .clkEn, .instrWord,
        .instrValid, .fileRdData, .accWrEn, .accWrData, .zeroWrEn,
        .zeroWrData, .fileWr, .accumulator, .zeroFlag, .optionReg,
        .instrDone, .instrOther);
    task automatic chk(input logic [33:0] e, input logic [33:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic wrap_up();
        if (q.size() != 0) n_fail++;
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic setw(input logic [7:0] a, input logic z);
        @(negedge mclk);
        {instrValid, accWrEn, accWrData, zeroWrEn, zeroWrData} = {2'h1, a, 1'h1, z};
        mAcc = a;
        mZ = z;
    endtask
    task automatic op(input logic [13:0] w, input logic [7:0] rd);
        logic [7:0] s;
        logic [15:0] wr;
        logic dn;
        @(negedge mclk);
        {instrWord, fileRdData, instrValid, accWrEn, zeroWrEn} = {w, rd, 3'h4};
        s = w[6:0] == OA ? mOpt : rd;
        wr = 16'h0;
        dn = 1'h1;
        if ((w & mvd_pkg::MOVE_FILE_MSK) == mvd_pkg::MOVE_FILE_VAL)
        begin
            mZ = s == 8'h00;
            if (!w[7]) mAcc = s;
            else if (w[6:0] == OA) mOpt = s;
            else wr = {1'h1, w[6:0], s};
        end
        else if ((w & mvd_pkg::STORE_ACC_MSK) == mvd_pkg::STORE_ACC_VAL)
        begin
            if (w[6:0] == OA) mOpt = mAcc;
            else wr = {1'h1, w[6:0], mAcc};
        end
        else if (w == mvd_pkg::OPT_LOAD_VAL) mOpt = mAcc;
        else dn = 1'h0;
        q.push_back({wr, mAcc, mZ, mOpt, dn});
    endtask
    // results land on the taking edge, so look 1 ns after it
    always @(posedge mclk)
    begin
        #1;
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            wrap_up();
        end
        if ((instrDone || instrOther) && q.size() == 0) n_fail++;
        else if (instrDone || instrOther)
            chk(q.pop_front(), {fileWr, accumulator, zeroFlag, optionReg, instrDone});
    end
    initial
    begin
        logic [13:0] w;
        int k;
        void'($urandom(32'h98e9));
        repeat (5) @(posedge mclk);
        @(negedge mclk) rstn = 1'h1;
        repeat (2) @(posedge mclk);
        op(14'h0805, 8'h00);
        setw(8'h4f, 1'h0);
        op(14'h0885, 8'h3c);
        op(14'h00a0, 8'h11);
        op(14'h0062, 8'h00);
        setw(8'ha5, 1'h1);
        op(14'h0081, 8'h00); // direct option store
        op(14'h0801, 8'h33);
        op(14'h0881, 8'h00);
        op(14'h3fff, 8'h12);
        repeat (60)
        begin
            setw(8'($urandom), 1'($urandom));
            repeat (2)
            begin
                k = $urandom_range(3);
                w = 14'($urandom);
                if (k == 0) w[13:8] = 6'h08;
                if (k == 1) w[13:7] = 7'h01;
                if (k == 2) w = 14'h0062;
                op(w, $urandom_range(1) ? 8'($urandom) : 8'h00);
            end
        end
        @(negedge mclk) instrValid = 1'h0;
        repeat (3) @(posedge mclk);
        wrap_up();
    end
endmodule
bind mvd_core mvd_core_assertions #(.OPT_ADDR(OPT_ADDR)) u_chk (.mclk,
    .rstn, .clkEn, .instrWord, .instrValid, .fileRdData, .accWrEn,
    .accWrData, .zeroWrEn, .zeroWrData, .fileWr, .accumulator,
    .zeroFlag, .optionReg, .instrDone, .instrOther);
`default_nettype wire
